// *** bench/pmc_far_side.sv ***
// pmc_far_side: camera module and density microphone facing pmc_top.
// assumes: bench sets the controls; syncs already active high after inversion.
`timescale 1ns/1ps
module pmc_far_side (
  input wire logic mclk,
  input wire logic camRun,
  input wire logic [2:0] syncMask,
  input wire logic [15:0] pixVal,
  input wire logic micRun,
  input wire logic bitClk,
  output logic pixClk,
  output logic [2:0] syncs,
  output logic [15:0] pixData,
  output logic pdmBit
);
  logic [1:0] phase;

  // known levels before the first frame
  initial begin
    phase = 2'h0;
    pixClk = 1'b0;
    pixData = 16'h0;
    pdmBit = 1'b0;
  end

  // camera: pixel clock only within frames, idle bus never repeats its last value
  always @(posedge mclk) begin
    phase <= camRun ? phase + 2'h1 : 2'h0;
    pixClk <= camRun && (phase == 2'h3) ? ~pixClk : pixClk & camRun;
    syncs <= camRun ? ~syncMask : 3'h0;
    pixData <= camRun ? pixVal : ~pixData;
  end

  // microphone: new bit after each falling bit-clock edge
  always @(negedge bitClk) begin
    pdmBit <= micRun ? 1'b1 : ~pdmBit;
  end
endmodule

// *** bench/pmc_properties.sv ***
// pmc_properties: port-level timing checks for pmc_top.
// assumes: bound to pmc_top; ctrl, freq and clkdiv registers are shadowed here from the port.
`timescale 1ns/1ps
module pmc_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [pmc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pmc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [pmc_pkg::DATA_W-1:0] regRdData,
  input wire logic word_select_output,
  input wire logic wordSelectOe,
  input wire logic converterClock
);
  // ------------------------------------------------------------
  // shadows
  // ------------------------------------------------------------
  pmc_pkg::pmc_ctrl_t ctrlCopy_reg;
  logic [19:0] freqCopy_reg;
  logic [15:0] divCopy_reg;

  // copies follow the write port
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlCopy_reg <= pmc_pkg::RST_CTRL;
      freqCopy_reg <= pmc_pkg::RST_FREQ;
      divCopy_reg <= pmc_pkg::RST_CLKDIV;
    end else if (regWrStrobe) begin
      if (regAddr == pmc_pkg::OFS_CTRL) ctrlCopy_reg <= regWrData[25:0];
      if (regAddr == pmc_pkg::OFS_FREQ) freqCopy_reg <= regWrData[19:0];
      if (regAddr == pmc_pkg::OFS_CLKDIV) divCopy_reg <= regWrData[15:0];
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // read data stands in one cycle only
  a_rd_idle_zero: assert property (!$past(regRdStrobe) |-> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property ($past(regRdStrobe) && $past(regAddr) > 8'h18
    |-> regRdData == 32'h0) else $error("unmapped read not zero");
  a_ctrl_readback: assert property ($past(regRdStrobe) &&
    $past(regAddr) == pmc_pkg::OFS_CTRL |-> regRdData == {6'h0, $past(ctrlCopy_reg)})
    else $error("ctrl readback wrong");
  a_freq_readback: assert property ($past(regRdStrobe) &&
    $past(regAddr) == pmc_pkg::OFS_FREQ |-> regRdData == {12'h0, $past(freqCopy_reg)})
    else $error("freq readback wrong");
  a_div_readback: assert property ($past(regRdStrobe) &&
    $past(regAddr) == pmc_pkg::OFS_CLKDIV |-> regRdData == {16'h0, $past(divCopy_reg)})
    else $error("clkdiv readback wrong");
  // oversample field is the integer quotient of the two rate fields
  a_sinc_status: assert property ($past(regRdStrobe) &&
    $past(regAddr) == pmc_pkg::OFS_STATUS && $past(freqCopy_reg[19:10]) != 10'h0
    |-> regRdData[15:6] == $past(freqCopy_reg[9:0]) / $past(freqCopy_reg[19:10]))
    else $error("oversample field wrong");
  // the pixel clock comes in, so the pin is never driven in camera mode
  a_camera_input: assert property (
    (ctrlCopy_reg.parallelModeEnable && ctrlCopy_reg.cameraEnable) [*3] |-> !wordSelectOe)
    else $error("word-select driven in camera mode");
  a_conv_quiet: assert property ((!ctrlCopy_reg.dacSelect) [*3] |-> !converterClock)
    else $error("converter clock outside converter mode");
  // writes excluded: a mode change may force the pin
  a_ws_pace: assert property ($changed(word_select_output) && divCopy_reg != 16'h0 &&
    !regWrStrobe && !$past(regWrStrobe) && !$past(regWrStrobe, 2)
    |=> $stable(word_select_output)) else $error("word-select faster than divider");
endmodule

bind pmc_top pmc_properties i_pmc_properties (.mclk(mclk), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
  .regRdData(regRdData), .word_select_output(word_select_output),
  .wordSelectOe(wordSelectOe), .converterClock(converterClock));

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for pmc_top with its far-side model.
// assumes: 100 MHz mclk, synchronous active-high srst, fixed stimulus.
`timescale 1ns/1ps
module tb_top;
  logic mclk, srst, regWrStrobe, regRdStrobe, halfPllTick, camRun, micRun;
  logic pixClk, pdmBit, wsOut, wsOe, pdmOut, convClk;
  logic [7:0] regAddr, dac1, dac2;
  logic [31:0] regWrData, regRdData, d;
  logic [2:0] syncMask, syncs;
  logic [15:0] pixVal, pixData;
  logic [23:0] lcdBus;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;

  pmc_top i_pmc_top (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .halfPllTick(halfPllTick), .word_select_input(pixClk), .horizontal_sync_in(syncs[2]),
    .vertical_sync_in(syncs[1]), .horizontal_enable_in(syncs[0]),
    .parallel_data_input(pixData), .densityDataIn(pdmBit), .word_select_output(wsOut),
    .wordSelectOe(wsOe), .densityDataOut(pdmOut), .lcdDataOut(lcdBus), .dac1Data(dac1),
    .dac2Data(dac2), .converterClock(convClk));
  pmc_far_side i_pmc_far_side (.mclk(mclk), .camRun(camRun), .syncMask(syncMask),
    .pixVal(pixVal), .micRun(micRun), .bitClk(wsOut), .pixClk(pixClk), .syncs(syncs),
    .pixData(pixData), .pdmBit(pdmBit));

  // ------------------------------------------------------------
  // clocks and shared tasks
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // converter source: one tick every other cycle
  always @(posedge mclk) halfPllTick <= srst ? 1'b0 : ~halfPllTick;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    n_mismatch++;
    $display("ERROR %0t no response: %s", $time, what);
    results();
  endtask
  // idle cycle after each strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStrobe <= 1'b1;
    @(posedge mclk);
    regWrStrobe <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge mclk);
    regRdStrobe <= 1'b0;
    #1 d = regRdData;
    @(posedge mclk);
  endtask
  // n: cycles spent polling
  task automatic stat(input int b, input logic v, input int lim);
    n = 0;
    do begin
      rd(pmc_pkg::OFS_STATUS);
      n += 2;
    end while (d[b] !== v && n < lim);
    if (d[b] !== v) hang("status");
  endtask
  // n: cycles to next clock rise
  task automatic rise(input bit conv);
    logic p;
    n = 0;
    do begin
      p = conv ? convClk : wsOut;
      @(posedge mclk);
      #1 n++;
    end while ((p || !(conv ? convClk : wsOut)) && n < 300);
    if (n >= 300) hang("clock edge");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    int num[6] = '{960, 441, 960, 960, 960, 960};
    int den[6] = '{480, 960, 320, 240, 160, 80};
    rd(pmc_pkg::OFS_CTRL);
    chk(d, 32'h0, "ctrl reset");
    rd(pmc_pkg::OFS_FREQ);
    chk(d, 32'h000783C0, "freq reset");
    wr(pmc_pkg::OFS_SHIFT, 32'hFFFF4321);
    rd(pmc_pkg::OFS_SHIFT);
    chk(d, 32'h00004321, "shift fields");
    rd(8'h20);
    chk(d, 32'h0, "unmapped");
    wr(pmc_pkg::OFS_CLKDIV, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(pmc_pkg::OFS_FREQ, {12'h0, 10'(den[i]), 10'(num[i])});
      rd(pmc_pkg::OFS_STATUS);
      chk({22'h0, d[15:6]}, num[i] / den[i], "oversample");
    end
    $display("t_regs done");
  endtask
  // one sample per 64*num/den bit periods
  task automatic t_dtx();
    int den[2] = '{960, 480};
    wr(pmc_pkg::OFS_CTRL, 32'h13);
    rise(0);
    rise(0);
    chk(n, 4, "density clock period");
    chk(wsOe, 1, "word-select driven");
    for (int i = 0; i < 2; i++) begin
      wr(pmc_pkg::OFS_FREQ, {12'h0, 10'(den[i]), 10'd960});
      wr(pmc_pkg::OFS_TXDATA, 32'h1234);
      stat(0, 0, 3000);
      wr(pmc_pkg::OFS_TXDATA, 32'h8000);
      stat(0, 0, 3000);
      chk((n + 16) / 128, 64 * 960 / den[i] * 4 / 128, "sample pacing");
    end
    $display("t_dtx done");
  endtask
  task automatic t_drx();
    micRun <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(pmc_pkg::OFS_CTRL, s ? 32'h2C : 32'h0C);
      stat(1, 1, 1500);
      rd(pmc_pkg::OFS_RXDATA);
      chk(d[31:16], 0, "pcm width");
      stat(1, 1, 1500);
      chk((n + 16) / 128, (64 << s) * 4 / 128, "decimation");
    end
    micRun <= 1'b0;
    $display("t_drx done");
  endtask
  task automatic t_lcd();
    for (int f = 0; f < 2; f++) begin
      wr(pmc_pkg::OFS_CTRL, f ? 32'hC40 : 32'h840);
      wr(pmc_pkg::OFS_TXDATA, {8'h5A, 24'hA5C33C ^ 24'(f)});
      repeat (4) rise(0);
      chk(n, 8, "strobe period");
      chk(lcdBus, 24'hA5C33C ^ 24'(f), "lcd bus");
      chk(wsOe, 1, "strobe driven");
    end
    $display("t_lcd done");
  endtask
  // one sync low at a time must stop capture
  task automatic t_cam();
    logic [2:0] m[3] = '{3'h1, 3'h2, 3'h4};
    pixVal <= 16'h5A3C;
    camRun <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      wr(pmc_pkg::OFS_CTRL, v ? 32'h4802C0 : 32'h1040);
      repeat (4) @(posedge mclk);
      rd(pmc_pkg::OFS_RXDATA);
      stat(1, 1, 400);
      rd(pmc_pkg::OFS_RXDATA);
      chk(d, 32'h00005A3C, "pixel word");
    end
    chk(wsOe, 0, "pixel clock input");
    for (int i = 0; i < 3; i++) begin
      syncMask <= m[i];
      repeat (8) @(posedge mclk);
      rd(pmc_pkg::OFS_RXDATA);
      repeat (40) @(posedge mclk);
      rd(pmc_pkg::OFS_STATUS);
      chk(d[2:1], 2'b00, "gated capture");
    end
    camRun <= 1'b0;
    $display("t_cam done");
  endtask
  task automatic t_dac();
    wr(pmc_pkg::OFS_CTRL, 32'h2001040);
    wr(pmc_pkg::OFS_TXDATA, 32'hC3007E00);
    rise(1);
    rise(1);
    chk(n, 8, "converter clock period");
    chk({dac2, dac1}, 16'hC37E, "dac lanes");
    $display("t_dac done");
  endtask

  // main sequence
  initial begin
    srst = 1'b1;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    halfPllTick = 1'b0;
    camRun = 1'b0;
    micRun = 1'b0;
    syncMask = 3'h0;
    pixVal = 16'h0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_dtx();
    t_drx();
    t_lcd();
    t_cam();
    t_dac();
    results();
  end
endmodule

// *** core/pmc_clk_div.sv ***
// pmc_clk_div: divides a source enable into a one-cycle tick.
// assumes: srcTick is a same-domain enable; divisor 0 means every source tick.
`timescale 1ns/1ps
module pmc_clk_div #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic run,
  input wire logic srcTick,
  input wire logic [W-1:0] divisor,
  output logic tick
);

  logic [W-1:0] cnt_reg;

  // ------------------------------------------------------------
  // counter: restarts whenever the block stops so phase is known
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || !run) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (srcTick) begin
        if (cnt_reg >= divisor) begin
          cnt_reg <= '0;
          tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule

// *** core/pmc_pkg.sv ***
// pmc_pkg: register map, field layouts, reset values and constants
// of the density-modulation / parallel-mode block.
// assumes: one 100 MHz clock, plain register port with 8-bit byte address.
package pmc_pkg;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SHIFT = 8'h04;
  localparam logic [7:0] OFS_FREQ = 8'h08;
  localparam logic [7:0] OFS_CLKDIV = 8'h0C;
  localparam logic [7:0] OFS_TXDATA = 8'h10;
  localparam logic [7:0] OFS_RXDATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ------------------------------------------------------------
  // field layouts (struct order is the bit order, msb first)
  // ------------------------------------------------------------
  typedef struct packed {
    logic dacSelect;
    logic [2:0] rxFifoFormat;
    logic [2:0] rxChannelMode;
    logic [2:0] txFifoFormat;
    logic [2:0] txChannelMode;
    logic convSelect;
    logic lcdStrobeDouble;
    logic lcdDataDouble;
    logic rxSlaveSelect;
    logic txSlaveSelect;
    logic cameraEnable;
    logic parallelModeEnable;
    logic rxDecimationSelect;
    logic txHighpassBypass;
    logic densityToPcmConvEnable;
    logic rxPdmEnable;
    logic pcmToDensityConvEnable;
    logic txPdmEnable;
  } pmc_ctrl_t;
  localparam int CTRL_W = 26;

  typedef struct packed {
    logic [3:0] highpassInputShift;
    logic [3:0] lowpassInputShift;
    logic [3:0] sincInputShift;
    logic [3:0] sigmaDeltaInputShift;
  } pmc_shift_t;
  localparam int SHIFT_W = 16;

  typedef struct packed {
    logic [9:0] upsampleDenominator;
    logic [9:0] upsampleNumerator;
  } pmc_freq_t;
  localparam int FREQ_W = 20;
  localparam int FREQ_DEN_LSB = 10;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [25:0] RST_CTRL = 26'h0000000;
  localparam logic [15:0] RST_SHIFT = 16'h0000;
  localparam logic [19:0] RST_FREQ = 20'h783C0;   // den 480, num 960
  localparam logic [15:0] RST_CLKDIV = 16'h0003;

  // ------------------------------------------------------------
  // widths and ratios
  // ------------------------------------------------------------
  localparam int PCM_W = 16;
  localparam int LCD_W = 24;
  localparam int CAM_W = 16;
  localparam int DAC_W = 8;
  localparam int DAC_SHIFT = 8;
  localparam int ACC_W = 20;
  localparam logic [6:0] UPSAMPLE_FACTOR = 7'h40;  // two cascaded x8 stages
  localparam logic [7:0] DEC_LONG = 8'h80;
  localparam logic [7:0] DEC_SHORT = 8'h40;
  localparam logic [3:0] HP_CORNER_SHIFT = 4'h8;
  localparam logic [3:0] LP_CORNER_SHIFT = 4'h2;
  localparam logic [3:0] SINC_STEP_SHIFT = 4'h2;
  localparam int SYNC_W = 20;

endpackage

// *** core/pmc_top.sv ***
// pmc_top: density-modulation and parallel (lcd/camera/converter) modes
// of the serial audio unit, with a small register port.
// assumes: density, word-select, sync and camera data pins come from outside and are synchronised here; the register port and halfPllTick are not.
`timescale 1ns/1ps
module pmc_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [pmc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pmc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [pmc_pkg::DATA_W-1:0] regRdData,
  input wire logic halfPllTick,
  input wire logic word_select_input,
  input wire logic horizontal_sync_in,
  input wire logic vertical_sync_in,
  input wire logic horizontal_enable_in,
  input wire logic [pmc_pkg::CAM_W-1:0] parallel_data_input,
  input wire logic densityDataIn,
  output logic word_select_output,
  output logic wordSelectOe,
  output logic densityDataOut,
  output logic [pmc_pkg::LCD_W-1:0] lcdDataOut,
  output logic [pmc_pkg::DAC_W-1:0] dac1Data,
  output logic [pmc_pkg::DAC_W-1:0] dac2Data,
  output logic converterClock
);

  pmc_pkg::pmc_ctrl_t ctrl_reg;
  pmc_pkg::pmc_shift_t shift_reg;
  pmc_pkg::pmc_freq_t freq_reg;
  logic [15:0] clkDiv_reg;
  logic [31:0] txWord_reg;
  logic txPending_reg;
  logic [31:0] rxWord_reg;
  logic rxValid_reg;
  logic [9:0] sincOsr_reg;
  logic [pmc_pkg::SYNC_W-1:0] pinMeta_reg;
  logic [pmc_pkg::SYNC_W-1:0] pinSync_reg;
  logic pclkPrev_reg;
  logic bck_reg;
  logic wsHalf_reg;
  logic bitTick;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic txDensity, rxDensity, parMode, camMode, convMode, lcdMode, dacMode, adcMode;
  assign txDensity = ctrl_reg.txPdmEnable & ctrl_reg.pcmToDensityConvEnable;
  assign rxDensity = ctrl_reg.rxPdmEnable & ctrl_reg.densityToPcmConvEnable;
  assign parMode = ctrl_reg.parallelModeEnable;
  assign camMode = parMode & ctrl_reg.cameraEnable & ctrl_reg.rxSlaveSelect;
  assign convMode = parMode & ~ctrl_reg.cameraEnable & ctrl_reg.convSelect;
  assign lcdMode = parMode & ~ctrl_reg.cameraEnable & ~ctrl_reg.convSelect
                   & ~ctrl_reg.txSlaveSelect;
  assign dacMode = convMode & ctrl_reg.dacSelect & ~ctrl_reg.txSlaveSelect;
  assign adcMode = convMode & ~ctrl_reg.dacSelect & ~ctrl_reg.rxSlaveSelect;

  // ------------------------------------------------------------
  // bit clock: one divider for density clock and parallel strobe
  // ------------------------------------------------------------
  logic clkRun, srcTick, bckRise, strobeRise;
  assign clkRun = (~parMode & (txDensity | rxDensity)) | lcdMode | dacMode | adcMode;
  assign srcTick = convMode ? halfPllTick : 1'b1;
  assign bckRise = bitTick & ~bck_reg;
  assign strobeRise = bckRise & ~wsHalf_reg;

  pmc_clk_div #(.W(16)) u_div (
    .mclk(mclk),
    .srst(srst),
    .run(clkRun),
    .srcTick(srcTick),
    .divisor(clkDiv_reg),
    .tick(bitTick)
  );

  // bit clock toggles per tick; word-select toggles per bit-clock period
  always_ff @(posedge mclk) begin
    if (srst || !clkRun) begin
      bck_reg <= 1'b0;
      wsHalf_reg <= 1'b0;
    end else begin
      if (bitTick) bck_reg <= ~bck_reg;
      if (bckRise) wsHalf_reg <= ~wsHalf_reg;
    end
  end

  // word-select pin: density clock, or half-rate strobe in parallel modes
  always_ff @(posedge mclk) begin
    if (srst) begin
      word_select_output <= 1'b0;
      wordSelectOe <= 1'b0;
      converterClock <= 1'b0;
    end else begin
      word_select_output <= parMode ? wsHalf_reg : bck_reg;
      wordSelectOe <= clkRun & ~camMode;
      converterClock <= dacMode & bck_reg;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers: nothing reads the first stage but the second
  // ------------------------------------------------------------
  logic [pmc_pkg::SYNC_W-1:0] pinRaw;
  assign pinRaw = {densityDataIn, word_select_input, horizontal_sync_in,
                   vertical_sync_in, horizontal_enable_in, parallel_data_input[14:0]};
  logic [pmc_pkg::CAM_W-1:0] camMeta_reg;
  logic [pmc_pkg::CAM_W-1:0] camSync_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      camMeta_reg <= '0;
      camSync_reg <= '0;
      pclkPrev_reg <= 1'b0;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
      camMeta_reg <= parallel_data_input;
      camSync_reg <= camMeta_reg;
      pclkPrev_reg <= pinSync_reg[18];
    end
  end

  logic pdmInS, pclkRise, syncsHigh;
  assign pdmInS = pinSync_reg[19];
  assign pclkRise = pinSync_reg[18] & ~pclkPrev_reg;
  assign syncsHigh = pinSync_reg[17] & pinSync_reg[16] & pinSync_reg[15];

  // ------------------------------------------------------------
  // density transmitter: rate, high-pass, sinc, low-pass, modulator
  // ------------------------------------------------------------
  localparam int AW = pmc_pkg::ACC_W;
  logic [16:0] fracAcc_reg;
  logic [16:0] fracSum, fracLimit;
  logic takeSample, densityBit;
  logic signed [AW-1:0] pcmIn, hpIn, hpOut, sincIn, lpIn, sdIn, feedback;
  logic signed [AW-1:0] hpAvg_reg, sincCur_reg, sincTgt_reg, lp_reg, integ_reg;
  logic [9:0] sincStep_reg;

  // one pcm sample per 64*num/den density bits
  assign fracSum = fracAcc_reg + {7'h00, freq_reg.upsampleDenominator};
  assign fracLimit = {10'h000, pmc_pkg::UPSAMPLE_FACTOR}
                     * {7'h00, freq_reg.upsampleNumerator};
  assign takeSample = txDensity & bckRise & (fracSum >= fracLimit);
  assign pcmIn = AW'(signed'(txWord_reg[pmc_pkg::PCM_W-1:0]));
  assign hpIn = pcmIn >>> shift_reg.highpassInputShift;
  assign hpOut = ctrl_reg.txHighpassBypass ? hpIn : hpIn - hpAvg_reg;
  assign sincIn = hpOut >>> shift_reg.sincInputShift;
  assign lpIn = sincCur_reg >>> shift_reg.lowpassInputShift;
  assign sdIn = lp_reg >>> shift_reg.sigmaDeltaInputShift;
  assign densityBit = (integ_reg + sdIn) >= 0;
  assign feedback = densityBit ? AW'(32767) : -AW'(32768);

  // rate accumulator and low-pass step once per density bit, high-pass once per sample
  always_ff @(posedge mclk) begin
    if (srst || !txDensity) begin
      fracAcc_reg <= '0;
      hpAvg_reg <= '0;
      sincCur_reg <= '0;
      sincTgt_reg <= '0;
      sincStep_reg <= '0;
      lp_reg <= '0;
      integ_reg <= '0;
      densityDataOut <= 1'b0;
    end else if (bckRise) begin
      fracAcc_reg <= takeSample ? fracSum - fracLimit : fracSum;
      if (takeSample) begin
        hpAvg_reg <= hpAvg_reg + ((hpIn - hpAvg_reg) >>> pmc_pkg::HP_CORNER_SHIFT);
        sincTgt_reg <= sincIn;
        sincStep_reg <= sincOsr_reg;
      end else if (sincStep_reg != 10'h000) begin
        sincCur_reg <= sincCur_reg + ((sincTgt_reg - sincCur_reg) >>> pmc_pkg::SINC_STEP_SHIFT);
        sincStep_reg <= sincStep_reg - 10'h001;
      end
      lp_reg <= lp_reg + ((lpIn - lp_reg) >>> pmc_pkg::LP_CORNER_SHIFT);
      integ_reg <= integ_reg + sdIn - feedback;  // first-order loop, bounded by feedback
      densityDataOut <= densityBit;
    end
  end

  // ------------------------------------------------------------
  // density receiver: count ones over 64 or 128 bits
  // ------------------------------------------------------------
  logic [7:0] decLen, decCnt_reg, ones_reg;
  logic [7:0] onesNext;
  logic [16:0] pcmScaled;
  logic rxDensityDone;
  assign decLen = ctrl_reg.rxDecimationSelect ? pmc_pkg::DEC_LONG : pmc_pkg::DEC_SHORT;
  assign onesNext = ones_reg + {7'h00, pdmInS};
  assign rxDensityDone = rxDensity & ~parMode & bckRise & (decCnt_reg == decLen - 8'h01);
  // scale ones to full range, offset to signed, saturate at the top
  assign pcmScaled = ctrl_reg.rxDecimationSelect ? {onesNext, 9'h000} : {onesNext[6:0], 10'h000};

  always_ff @(posedge mclk) begin
    if (srst || !rxDensity) begin
      decCnt_reg <= '0;
      ones_reg <= '0;
    end else if (bckRise) begin
      decCnt_reg <= rxDensityDone ? 8'h00 : decCnt_reg + 8'h01;
      ones_reg <= rxDensityDone ? 8'h00 : onesNext;
    end
  end

  // ------------------------------------------------------------
  // parallel transmit: lcd strobes and dac words
  // ------------------------------------------------------------
  logic [1:0] strobeCnt_reg;
  logic [1:0] strobesPerWord;
  logic lcdWordDone, dacWordDone;
  assign strobesPerWord = {ctrl_reg.lcdStrobeDouble & ctrl_reg.lcdDataDouble,
                           ctrl_reg.lcdStrobeDouble ^ ctrl_reg.lcdDataDouble};
  assign lcdWordDone = lcdMode & strobeRise & (strobeCnt_reg == strobesPerWord);
  assign dacWordDone = dacMode & strobeRise;

  always_ff @(posedge mclk) begin
    if (srst) begin
      strobeCnt_reg <= '0;
      lcdDataOut <= '0;
      dac1Data <= '0;
      dac2Data <= '0;
    end else begin
      if (!lcdMode || lcdWordDone) begin
        strobeCnt_reg <= '0;
      end else if (strobeRise) begin
        strobeCnt_reg <= strobeCnt_reg + 2'h1;
      end
      // word is presented for all strobes of its frame
      if (lcdMode && strobeRise && strobeCnt_reg == 2'h0) begin
        lcdDataOut <= txWord_reg[pmc_pkg::LCD_W-1:0];
      end
      if (dacWordDone) begin
        dac1Data <= txWord_reg[pmc_pkg::DAC_SHIFT +: pmc_pkg::DAC_W];
        dac2Data <= txWord_reg[16 + pmc_pkg::DAC_SHIFT +: pmc_pkg::DAC_W];
      end
    end
  end

  // ------------------------------------------------------------
  // register port: writes, sample flags, read data one cycle later
  // ------------------------------------------------------------
  logic wrCtrl, wrTx, rdRx, txConsume, rxCapture;
  logic [31:0] rxCaptured;
  assign wrCtrl = regWrStrobe & (regAddr == pmc_pkg::OFS_CTRL);
  assign wrTx = regWrStrobe & (regAddr == pmc_pkg::OFS_TXDATA);
  assign rdRx = regRdStrobe & (regAddr == pmc_pkg::OFS_RXDATA);
  assign txConsume = takeSample | lcdWordDone | dacWordDone;

  // capture sources are exclusive by mode
  always_comb begin
    rxCapture = 1'b0;
    rxCaptured = rxWord_reg;
    if (camMode && pclkRise && syncsHigh) begin
      rxCapture = 1'b1;
      rxCaptured = {16'h0000, camSync_reg};
    end else if (adcMode && strobeRise) begin
      rxCapture = 1'b1;
      rxCaptured = {16'h0000, camSync_reg};
    end else if (rxDensityDone) begin
      rxCapture = 1'b1;
      rxCaptured = {16'h0000, pcmScaled[16] ? 16'h7FFF : pcmScaled[15:0] ^ 16'h8000};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= pmc_pkg::RST_CTRL;
      shift_reg <= pmc_pkg::RST_SHIFT;
      freq_reg <= pmc_pkg::RST_FREQ;
      clkDiv_reg <= pmc_pkg::RST_CLKDIV;
    end else if (regWrStrobe) begin
      if (wrCtrl) ctrl_reg <= regWrData[pmc_pkg::CTRL_W-1:0];
      if (regAddr == pmc_pkg::OFS_SHIFT) shift_reg <= regWrData[pmc_pkg::SHIFT_W-1:0];
      if (regAddr == pmc_pkg::OFS_FREQ) freq_reg <= regWrData[pmc_pkg::FREQ_W-1:0];
      if (regAddr == pmc_pkg::OFS_CLKDIV) clkDiv_reg <= regWrData[15:0];
    end
  end

  // sinc ratio kept registered so the divider stays off the sample path
  always_ff @(posedge mclk) begin
    if (srst) begin
      sincOsr_reg <= '0;
    end else if (freq_reg.upsampleDenominator != 10'h000) begin
      sincOsr_reg <= freq_reg.upsampleNumerator / freq_reg.upsampleDenominator;
    end else begin
      sincOsr_reg <= '0;
    end
  end

  // transmit word: a new write wins over consumption in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      txWord_reg <= '0;
      txPending_reg <= 1'b0;
    end else if (wrTx) begin
      txWord_reg <= regWrData;
      txPending_reg <= 1'b1;
    end else if (txConsume) begin
      txPending_reg <= 1'b0;  // word is held and repeated on underrun
    end
  end

  // receive word: a capture wins over the read that clears the flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxWord_reg <= '0;
      rxValid_reg <= 1'b0;
    end else if (rxCapture) begin
      rxWord_reg <= rxCaptured;
      rxValid_reg <= 1'b1;
    end else if (rdRx) begin
      rxValid_reg <= 1'b0;
    end
  end

  // read mux, unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdData <= '0;
    end else if (regRdStrobe) begin
      unique case (regAddr)
        pmc_pkg::OFS_CTRL: regRdData <= {6'h00, ctrl_reg};
        pmc_pkg::OFS_SHIFT: regRdData <= {16'h0000, shift_reg};
        pmc_pkg::OFS_FREQ: regRdData <= {12'h000, freq_reg};
        pmc_pkg::OFS_CLKDIV: regRdData <= {16'h0000, clkDiv_reg};
        pmc_pkg::OFS_TXDATA: regRdData <= txWord_reg;
        pmc_pkg::OFS_RXDATA: regRdData <= rxWord_reg;
        pmc_pkg::OFS_STATUS: regRdData <= {16'h0000, sincOsr_reg, clkRun, wsHalf_reg,
                                           bck_reg, syncsHigh, rxValid_reg, txPending_reg};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule
